// ===== inc/mgbs_regs.svh
// register offsets, reset values and pin masks of the gpio and boot strap block
`ifndef MGBS_REGS_SVH
`define MGBS_REGS_SVH

// register byte offsets, one aligned word each
`define MGBS_OFF_CFG0 8'h00
`define MGBS_OFF_CFG1 8'h04
`define MGBS_OFF_CFG2 8'h08
`define MGBS_OFF_CFG3 8'h0C
`define MGBS_OFF_LEVEL 8'h10
`define MGBS_OFF_TRIG_EN 8'h14
`define MGBS_OFF_TRIG_RISE 8'h18
`define MGBS_OFF_EVENT 8'h1C
`define MGBS_OFF_BOOT 8'h20
`define MGBS_OFF_DISPLAY 8'h24

// field layout
`define MGBS_CFG_FIELD_W 4
`define MGBS_PINS_PER_CFG 8
`define MGBS_DISPLAY_WIDE_BIT 0
`define MGBS_BOOT_SEL_LSB 0
`define MGBS_BOOT_RAW_LSB 8
`define MGBS_STRAP_OVERRIDE_BIT 4

// reset values
`define MGBS_RST_WORD 32'h0000_0000
`define MGBS_RST_BOOT 2'h0

// pins that may be used as general purpose (bit 31 is a dedicated input)
`define MGBS_GPIO_MASK 32'h7FFF_FFFF
// connector positions that carry the test port in 18-bit colour mode
`define MGBS_JTAG_MASK 32'h7E00_0000
// strap pins: display data bits 0 to 4
`define MGBS_STRAP_MASK 32'h0000_001F

// core fetch address after reset, arbitrary on-chip rom base
`define MGBS_BOOT_ROM_BASE 32'hFFFF_0000
// cycles spent letting the strap pins settle through the synchroniser
`define MGBS_STRAP_SETTLE 2'h3

`endif

// ===== inc/mgbs_pkg.sv
// types of the gpio and boot strap block
package mgbs_pkg;

    // per-pin configuration codes
    typedef enum logic [2:0] {
        MGBS_MODE_HIZ = 3'h0,
        MGBS_MODE_LOW = 3'h1,
        MGBS_MODE_HIGH = 3'h2,
        MGBS_MODE_PER0 = 3'h3,
        MGBS_MODE_PER1 = 3'h4,
        MGBS_MODE_PER2 = 3'h5
    } mgbs_mode_t;

    // boot sources
    typedef enum logic [1:0] {
        MGBS_BOOT_FLASH = 2'h0,
        MGBS_BOOT_SD = 2'h1,
        MGBS_BOOT_USB = 2'h2,
        MGBS_BOOT_JTAG = 2'h3
    } mgbs_boot_t;

    // reset sequencer states, one-hot
    typedef enum logic [2:0] {
        MGBS_ST_RESET = 3'b001,
        MGBS_ST_STRAP = 3'b010,
        MGBS_ST_RUN = 3'b100
    } mgbs_state_t;

    // drive of a group of 32 pins
    typedef struct packed {
        logic [31:0] value;
        logic [31:0] enable;
    } mgbs_drive_t;

    // fuse boot setting from on-chip logic
    typedef struct packed {
        logic programmed;
        mgbs_boot_t source;
    } mgbs_fuse_t;

endpackage

// ===== hw/mgbs_sync.sv
// two flip-flop synchroniser for the 32 pad inputs
`timescale 1ns/1ps
module mgbs_sync
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [31:0] async_in,
    output logic [31:0] sync_out
);
    logic [31:0] stage1;

    // first stage feeds only the second stage
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            stage1 <= 32'h0000_0000;
            sync_out <= 32'h0000_0000;
        end
        else
        begin
            stage1 <= async_in;
            sync_out <= stage1;
        end
    end
endmodule

// ===== hw/mgbs_top.sv
// gpio pin control, boot strap decode and display connector option
// ----------------------------------------------------------------------
// How it works
// - each pin can be driven low, driven high or released to high impedance.
// - every pin configuration is writable any time, including three peripherals.
// - the synchronised level of every pin except dedicated pin 31 is readable regardless of its mode.
// - every pin except dedicated pin 31 can raise a rising or falling edge trigger event.
// - analog pins get no output drive and read back as zero; none here, codes 6 and 7 only release the pin.
// - dedicated pins are excluded from general purpose control.
// - after power-on reset the core is pointed at the boot rom.
// - display data bits 0 to 4 sampled after reset release decode to boot select.
// - without strap override or programmed fuses the boot source is flash.
// - by default the connector carries 18-bit colour plus the test port.
// - the 24-bit option gives test-port positions to upper display lines.
// ----------------------------------------------------------------------
//
// Chosen here: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
`include "mgbs_regs.svh"
module mgbs_top
(
    input wire logic clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [31:0] pad_in,
    output logic [31:0] pad_out,
    output logic [31:0] pad_oe,
    input wire mgbs_pkg::mgbs_drive_t periph0,
    input wire mgbs_pkg::mgbs_drive_t periph1,
    input wire mgbs_pkg::mgbs_drive_t periph2,
    input wire mgbs_pkg::mgbs_drive_t jtag_drive,
    input wire logic [5:0] display_upper_data,
    input wire mgbs_pkg::mgbs_fuse_t fuse_boot,
    output logic [31:0] pin_level,
    output logic [31:0] pin_trigger,
    output logic [31:0] jtag_in,
    output logic [1:0] boot_select,
    output logic core_hold,
    output logic [31:0] core_fetch_addr,
    output logic display_wide
);
    import mgbs_pkg::*;

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------

    // value and enable of one pin for its configured mode
    function automatic logic [1:0] pin_drive(input logic [2:0] mode,
        input logic [1:0] p0, input logic [1:0] p1, input logic [1:0] p2);
        logic [1:0] d;
        d = 2'b00;
        case (mode)
            MGBS_MODE_LOW: d = 2'b01;
            MGBS_MODE_HIGH: d = 2'b11;
            MGBS_MODE_PER0: d = p0;
            MGBS_MODE_PER1: d = p1;
            MGBS_MODE_PER2: d = p2;
            default: d = 2'b00;
        endcase
        return d;
    endfunction

    // strap pattern to boot source, fuses below the strap override
    function automatic logic [1:0] boot_decode(input logic [4:0] strap,
        input mgbs_fuse_t fuse);
        logic [1:0] sel;
        sel = MGBS_BOOT_FLASH;
        if (strap[`MGBS_STRAP_OVERRIDE_BIT])
            sel = strap[1:0];
        else if (fuse.programmed)
            sel = fuse.source;
        return sel;
    endfunction

    // ------------------------------------------------------------------
    // storage
    // ------------------------------------------------------------------
    logic [31:0] cfg_word [4];
    logic [31:0] trig_en;
    logic [31:0] trig_rise;
    logic [31:0] event_flag;
    logic [31:0] level_prev;
    logic [4:0] strap_raw;
    logic [1:0] settle_cnt;
    mgbs_state_t state;
    mgbs_state_t next_state;
    logic [31:0] pad_sync;

    // pad inputs cross into the clock domain first
    mgbs_sync u_sync
    (
        .clk(clk),
        .rst(rst),
        .async_in(pad_in),
        .sync_out(pad_sync)
    );

    // ------------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------------
    wire setup_phase = psel && !penable;
    wire access_done = psel && penable && pready;
    wire wr_done = access_done && pwrite;
    wire [7:0] reg_off = paddr[7:0];
    wire upper_zero = (paddr[31:8] == 24'h00_0000);
    wire hit_cfg0 = upper_zero && (reg_off == `MGBS_OFF_CFG0);
    wire hit_cfg1 = upper_zero && (reg_off == `MGBS_OFF_CFG1);
    wire hit_cfg2 = upper_zero && (reg_off == `MGBS_OFF_CFG2);
    wire hit_cfg3 = upper_zero && (reg_off == `MGBS_OFF_CFG3);
    wire hit_level = upper_zero && (reg_off == `MGBS_OFF_LEVEL);
    wire hit_trig_en = upper_zero && (reg_off == `MGBS_OFF_TRIG_EN);
    wire hit_trig_rise = upper_zero && (reg_off == `MGBS_OFF_TRIG_RISE);
    wire hit_event = upper_zero && (reg_off == `MGBS_OFF_EVENT);
    wire hit_boot = upper_zero && (reg_off == `MGBS_OFF_BOOT);
    wire hit_display = upper_zero && (reg_off == `MGBS_OFF_DISPLAY);
    wire addr_hit = hit_cfg0 || hit_cfg1 || hit_cfg2 || hit_cfg3
        || hit_level || hit_trig_en || hit_trig_rise || hit_event
        || hit_boot || hit_display;
    wire [3:0] cfg_we = {hit_cfg3, hit_cfg2, hit_cfg1, hit_cfg0}
        & {4{wr_done}};

    // per-pin config fields: only 3 of 4 bits are kept
    wire [31:0] cfg_mask = 32'h7777_7777;
    wire [31:0] boot_word = {19'h0_0000, strap_raw, 6'h00,
        boot_select};

    // read mux, if and else-if chain
    logic [31:0] read_mux;
    always_comb
    begin
        if (hit_cfg0)
            read_mux = cfg_word[0];
        else if (hit_cfg1)
            read_mux = cfg_word[1];
        else if (hit_cfg2)
            read_mux = cfg_word[2];
        else if (hit_cfg3)
            read_mux = cfg_word[3];
        else if (hit_level)
            read_mux = pin_level;
        else if (hit_trig_en)
            read_mux = trig_en;
        else if (hit_trig_rise)
            read_mux = trig_rise;
        else if (hit_event)
            read_mux = event_flag;
        else if (hit_boot)
            read_mux = boot_word;
        else if (hit_display)
            read_mux = {31'h0000_0000, display_wide};
        else
            read_mux = 32'h0000_0000;
    end

    // one wait-free access phase; answer registered at the setup cycle
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            pready <= 1'b0;
            prdata <= `MGBS_RST_WORD;
            pslverr <= 1'b0;
        end
        else
        begin
            pready <= setup_phase;
            prdata <= setup_phase && !pwrite ? read_mux : `MGBS_RST_WORD;
            pslverr <= setup_phase && !addr_hit;
        end
    end

    // ------------------------------------------------------------------
    // configuration registers
    // ------------------------------------------------------------------

    // all general purpose pins start as high impedance inputs, any write takes effect now
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            for (int w = 0; w < 4; w++)
                cfg_word[w] <= `MGBS_RST_WORD;
        end
        else
        begin
            for (int w = 0; w < 4; w++)
                if (cfg_we[w])
                    cfg_word[w] <= pwdata & cfg_mask;
        end
    end

    // trigger setup and display option
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            trig_en <= `MGBS_RST_WORD;
            trig_rise <= `MGBS_RST_WORD;
            display_wide <= 1'b0;
        end
        else
        begin
            if (wr_done && hit_trig_en)
                trig_en <= pwdata & `MGBS_GPIO_MASK;
            if (wr_done && hit_trig_rise)
                trig_rise <= pwdata;
            if (wr_done && hit_display)
                display_wide <= pwdata[`MGBS_DISPLAY_WIDE_BIT];
        end
    end

    // ------------------------------------------------------------------
    // pin drive
    // ------------------------------------------------------------------
    logic [31:0] gpio_value;
    logic [31:0] gpio_enable;
    genvar gp;
    generate
        for (gp = 0; gp < 32; gp++)
        begin : g_pin
            wire [3:0] field = cfg_word[gp / 8][(gp % 8) * 4 +: 4];
            wire [1:0] drv = pin_drive(field[2:0],
                {periph0.value[gp], periph0.enable[gp]},
                {periph1.value[gp], periph1.enable[gp]},
                {periph2.value[gp], periph2.enable[gp]});
            assign gpio_value[gp] = drv[1];
            assign gpio_enable[gp] = drv[0];
        end
    endgenerate

    // test-port positions: test port in 18-bit mode, upper data in 24-bit
    wire [31:0] upper_value = {1'b0, display_upper_data, 25'h000_0000};
    wire [31:0] jtag_pos = `MGBS_JTAG_MASK;
    wire [31:0] owned_value = display_wide ? upper_value
        : jtag_drive.value;
    wire [31:0] owned_enable = display_wide ? jtag_pos
        : jtag_drive.enable;
    // general purpose control only where the pin is not dedicated
    wire [31:0] free_pins = `MGBS_GPIO_MASK & ~jtag_pos;
    wire [31:0] next_pad_out = (gpio_value & free_pins)
        | (owned_value & jtag_pos);
    wire [31:0] next_pad_oe = (gpio_enable & free_pins)
        | (owned_enable & jtag_pos);

    // drive is registered, so a config write shows one cycle later
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            pad_out <= `MGBS_RST_WORD;
            pad_oe <= `MGBS_RST_WORD;
        end
        else
        begin
            pad_out <= next_pad_out;
            pad_oe <= next_pad_oe & ~(core_hold ? `MGBS_STRAP_MASK
                : 32'h0000_0000);
        end
    end

    // ------------------------------------------------------------------
    // level readback and triggers
    // ------------------------------------------------------------------
    wire [31:0] rise_edge = pad_sync & ~level_prev;
    wire [31:0] fall_edge = ~pad_sync & level_prev;
    wire [31:0] next_trigger = trig_en & `MGBS_GPIO_MASK
        & ((trig_rise & rise_edge) | (~trig_rise & fall_edge));
    wire [31:0] event_clear = wr_done && hit_event ? pwdata
        : 32'h0000_0000;
    // a new event beats a write-one-to-clear in the same cycle
    wire [31:0] next_event = (event_flag & ~event_clear) | next_trigger;

    // level follows the pad on every pin but 31, whatever drives it
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            level_prev <= `MGBS_RST_WORD;
            pin_level <= `MGBS_RST_WORD;
            pin_trigger <= `MGBS_RST_WORD;
            event_flag <= `MGBS_RST_WORD;
            jtag_in <= `MGBS_RST_WORD;
        end
        else
        begin
            level_prev <= pad_sync;
            pin_level <= pad_sync & `MGBS_GPIO_MASK;
            pin_trigger <= next_trigger;
            event_flag <= next_event;
            jtag_in <= display_wide ? 32'h0000_0000 : pad_sync & jtag_pos;
        end
    end

    // ------------------------------------------------------------------
    // reset sequencer and boot strap
    // ------------------------------------------------------------------
    always_comb
    begin
        next_state = state;
        case (state)
            MGBS_ST_RESET: next_state = MGBS_ST_STRAP;
            MGBS_ST_STRAP:
                if (settle_cnt == 2'h0)
                    next_state = MGBS_ST_RUN;
            MGBS_ST_RUN: next_state = MGBS_ST_RUN;
            default: next_state = MGBS_ST_RESET;
        endcase
    end

    // strap caught by a clocked process after release, never by the reset
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            state <= MGBS_ST_RESET;
            settle_cnt <= `MGBS_STRAP_SETTLE;
            strap_raw <= 5'h00;
            boot_select <= `MGBS_RST_BOOT;
            core_hold <= 1'b1;
            core_fetch_addr <= `MGBS_BOOT_ROM_BASE;
        end
        else
        begin
            state <= next_state;
            if (state == MGBS_ST_STRAP)
                settle_cnt <= settle_cnt - 2'h1;
            if (state == MGBS_ST_STRAP && settle_cnt == 2'h0)
            begin
                strap_raw <= pad_sync[4:0];
                boot_select <= boot_decode(pad_sync[4:0], fuse_boot);
                core_hold <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    // strap pins stay released while the core is held, so skip that time
    sequence s_hi_cfg_write;
        !core_hold && wr_done && hit_cfg0 && pwdata[3:0] == 4'h2;
    endsequence

    AST_DRIVE_HIGH: assert property (s_hi_cfg_write ##1 !cfg_we[0]
        |=> pad_out[0] && pad_oe[0])
        else $error("pin 0 not driven high after high config");
    AST_HIZ_NO_OE: assert property (cfg_word[0][3:0] == 4'h0 |=>
        !pad_oe[0])
        else $error("pin 0 driven while configured high impedance");
    AST_PER1_OWNS: assert property (!core_hold
        && cfg_word[0][7:4] == 4'h4
        |=> pad_oe[1] == $past(periph1.enable[1]))
        else $error("peripheral 1 does not own pin 1");
    AST_LEVEL_READ: assert property (pin_level[2]
        == $past(pad_sync[2]))
        else $error("level readback does not follow pad");
    AST_TRIG_CAUSE: assert property (pin_trigger[3] |->
        $past(trig_en[3]) && $past(pad_sync[3]) != $past(level_prev[3]))
        else $error("trigger without enabled edge");
    AST_DEDICATED: assert property (!pad_oe[31] && !pin_level[31]
        && !pin_trigger[31])
        else $error("dedicated pin under gpio control");
    AST_ROM_FETCH: assert property (
        core_fetch_addr == `MGBS_BOOT_ROM_BASE
        && (state != MGBS_ST_RUN) == core_hold)
        else $error("core not held at boot rom");
    AST_STRAP_HIZ: assert property (core_hold |=> pad_oe[4:0] == 5'h00)
        else $error("strap pins driven during sampling");
    AST_FLASH_DEF: assert property ($rose(state == MGBS_ST_RUN)
        && !strap_raw[4] && !$past(fuse_boot.programmed)
        |-> boot_select == MGBS_BOOT_FLASH)
        else $error("default boot is not flash");
    AST_NARROW_JTAG: assert property (!display_wide |=>
        pad_oe[30:25] == $past(jtag_drive.enable[30:25]))
        else $error("test port positions not owned by test port");
    AST_WIDE_DATA: assert property (display_wide |=>
        pad_oe[30:25] == 6'h3F && jtag_in == 32'h0000_0000)
        else $error("upper display lines not on connector");
    AST_RESET_HIZ: assert property ($fell(rst) |-> pad_oe == 32'h0)
        else $error("pins not high impedance after reset");
endmodule

// ===== test/mgbs_board.sv
// board side model: pad resolution, strap resistors and external drivers
`timescale 1ns/1ps
module mgbs_board
(
    input wire logic [31:0] pad_out,
    input wire logic [31:0] pad_oe,
    input wire logic [31:0] ext_level,
    input wire logic [31:0] ext_oe,
    output logic [31:0] pad_in
);
    // ------------------------------------------------------------------
    // pad resolution
    // ------------------------------------------------------------------
    // a pin nobody drives sinks to the pull-down, never a stale level
    always_comb
    begin
        for (int i = 0; i < 32; i++)
        begin
            if (pad_oe[i])
                pad_in[i] = pad_out[i];
            else if (ext_oe[i])
                pad_in[i] = ext_level[i];
            else
                pad_in[i] = 1'b0;
        end
    end
endmodule

// ===== test/mgbs_top_tb.sv
// self-checking bench of the gpio and boot strap block
`timescale 1ns/1ps
`include "mgbs_regs.svh"
`define CHK(got, exp) \
    begin \
        num_checks++; \
        if ((got) !== (exp)) \
        begin \
            error_cnt++; \
            $display("[ERR] %0t got %0h exp %0h", $time, (got), (exp)); \
        end \
    end
module mgbs_top_tb;
    import mgbs_pkg::*;
    logic clk, rst, psel, penable, pwrite, pready, pslverr, core_hold;
    logic display_wide, err;
    logic [31:0] paddr, pwdata, prdata, pad_in, pad_out, pad_oe, rd;
    logic [31:0] pin_level, pin_trigger, jtag_in, core_fetch_addr;
    logic [31:0] ext_level, ext_oe;
    logic [5:0] display_upper_data;
    logic [1:0] boot_select, e;
    logic [7:0] v;
    logic [7:0] corner [4] = '{8'h00, 8'h13, 8'hC3, 8'hB1};
    mgbs_drive_t periph0, periph1, periph2, jtag_drive;
    mgbs_fuse_t fuse_boot;
    int error_cnt, num_checks, p, m, hits;

    // ------------------------------------------------------------------
    // design and board
    // ------------------------------------------------------------------
    mgbs_top mgbs_top_i (.clk(clk), .rst(rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe),
        .periph0(periph0), .periph1(periph1), .periph2(periph2),
        .jtag_drive(jtag_drive), .display_upper_data(display_upper_data),
        .fuse_boot(fuse_boot), .pin_level(pin_level),
        .pin_trigger(pin_trigger), .jtag_in(jtag_in),
        .boot_select(boot_select), .core_hold(core_hold),
        .core_fetch_addr(core_fetch_addr), .display_wide(display_wide));
    mgbs_board mgbs_board_i (.pad_out(pad_out), .pad_oe(pad_oe),
        .ext_level(ext_level), .ext_oe(ext_oe), .pad_in(pad_in));

    // ------------------------------------------------------------------
    // clock, watchdog and verdict
    // ------------------------------------------------------------------
    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // generous span: the sequence needs well under 5000 cycles
    initial
    begin
        #200000;
        error_cnt++;
        test_done();
    end

    task automatic test_done();
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // ------------------------------------------------------------------
    // bus tasks and expectations
    // ------------------------------------------------------------------
    // entered just after a rising edge; one idle cycle left between calls
    task automatic apb(input logic wr, input logic [31:0] a,
        input logic [31:0] d);
        int n;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (pready !== 1'b1 && n < 16);
        if (n >= 16)
            error_cnt++;
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask

    // {enable, enable and value} expected on a general pin
    function automatic logic [1:0] exp_drv(input int md, input int pn);
        case (md)
            1: return 2'b10;
            2: return 2'b11;
            3: return {periph0.enable[pn], periph0.enable[pn] & periph0.value[pn]};
            4: return {periph1.enable[pn], periph1.enable[pn] & periph1.value[pn]};
            5: return {periph2.enable[pn], periph2.enable[pn] & periph2.value[pn]};
            default: return 2'b00;
        endcase
    endfunction

    function automatic logic [1:0] exp_boot(input logic [7:0] sf);
        if (sf[4])
            return sf[1:0];
        if (sf[7])
            return sf[6:5];
        return 2'h0;
    endfunction

    // straps are held by the board across reset and sampled a few cycles after release
    task automatic do_reset(input logic [7:0] sf);
        int n;
        rst <= 1'b1;
        fuse_boot <= sf[7:5];
        ext_oe <= 32'h0000_001F;
        ext_level <= {27'h0, sf[4:0]};
        repeat (5) @(posedge clk);
        `CHK(pad_oe, 32'h0)
        `CHK(core_fetch_addr, 32'hFFFF_0000)
        rst <= 1'b0;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (core_hold !== 1'b0 && n < 16);
        `CHK(core_hold, 1'b0)
        `CHK(boot_select, exp_boot(sf))
        apb(1'b0, `MGBS_OFF_BOOT, 32'h0);
        `CHK(rd[12:0], {sf[4:0], 6'h0, exp_boot(sf)})
        apb(1'b0, `MGBS_OFF_CFG0, 32'h0);
        `CHK(rd, 32'h0)
        `CHK(display_wide, 1'b0)
    endtask

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial
    begin
        rst = 1'b1;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {periph0, periph1, periph2, jtag_drive} = '0;
        display_upper_data = 6'h0;
        fuse_boot = 3'h0;
        ext_level = 32'h0;
        ext_oe = 32'h0;
        void'($urandom(22));
        @(posedge clk);
        for (int i = 0; i < 8; i++)
        begin
            v = (i < 4) ? corner[i] : 8'($urandom);
            do_reset(v);
        end
        $display("test boot strap done");

        periph0 <= {$urandom, $urandom};
        periph1 <= {$urandom, $urandom};
        periph2 <= {$urandom, $urandom};
        jtag_drive <= {$urandom, $urandom};
        display_upper_data <= 6'($urandom);
        ext_oe <= $urandom;
        ext_level <= $urandom;
        for (int k = 0; k < 24; k++)
        begin
            p = 5 + $urandom % 20;
            m = k % 8;
            apb(1'b1, 32'((p / 8) * 4), 32'(m) << ((p % 8) * 4));
            // drive is registered: look two edges after the write lands
            @(posedge clk);
            e = exp_drv(m, p);
            `CHK({pad_oe[p], pad_oe[p] & pad_out[p]}, e)
            repeat (4) @(posedge clk);
            e[0] = e[1] ? e[0] : ext_oe[p] & ext_level[p];
            `CHK(pin_level[p], e[0])
            apb(1'b0, `MGBS_OFF_LEVEL, 32'h0);
            `CHK(rd[p], e[0])
            `CHK(err, 1'b0)
        end
        // pin 0 driven high, pin 1 handed to the second peripheral
        apb(1'b1, `MGBS_OFF_CFG0, 32'h0000_0042);
        @(posedge clk);
        `CHK({pad_oe[1:0], pad_out[0]}, {periph1.enable[1], 2'b11})
        $display("test pin modes done");

        // rising then falling trigger, each preceded by the ignored edge
        p = 5 + $urandom % 20;
        apb(1'b1, 32'((p / 8) * 4), 32'h0);
        ext_oe[p] <= 1'b1;
        apb(1'b1, `MGBS_OFF_TRIG_EN, 32'h1 << p);
        for (int r = 1; r >= 0; r--)
        begin
            apb(1'b1, `MGBS_OFF_TRIG_RISE, 32'(r) << p);
            ext_level[p] <= r[0];
            repeat (8) @(posedge clk);
            apb(1'b1, `MGBS_OFF_EVENT, 32'hFFFF_FFFF);
            ext_level[p] <= ~r[0];
            repeat (8) @(posedge clk);
            apb(1'b0, `MGBS_OFF_EVENT, 32'h0);
            `CHK(rd, 32'h0)
            ext_level[p] <= r[0];
            hits = 0;
            repeat (8)
            begin
                @(posedge clk);
                if (pin_trigger[p] === 1'b1)
                    hits++;
            end
            `CHK(hits, 1)
            apb(1'b0, `MGBS_OFF_EVENT, 32'h0);
            `CHK(rd, 32'h1 << p)
            apb(1'b1, `MGBS_OFF_EVENT, 32'h1 << p);
            apb(1'b0, `MGBS_OFF_EVENT, 32'h0);
            `CHK(rd, 32'h0)
        end
        $display("test trigger done");

        // every field of the top word asks for a driven high
        apb(1'b1, `MGBS_OFF_CFG3, 32'h2222_2222);
        ext_oe[31] <= 1'b1;
        ext_level[31] <= 1'b1;
        repeat (6) @(posedge clk);
        `CHK(pad_oe[31], 1'b0)
        `CHK({pad_oe[24], pad_out[24]}, 2'b11)
        `CHK(pad_oe[30:25], jtag_drive.enable[30:25])
        `CHK(pin_level[31], 1'b0)
        // test port inputs follow the resolved pads on their positions
        rd = (jtag_drive.enable & jtag_drive.value)
            | (~jtag_drive.enable & ext_oe & ext_level);
        `CHK(jtag_in, rd & `MGBS_JTAG_MASK)
        apb(1'b0, `MGBS_OFF_LEVEL, 32'h0);
        `CHK(rd[31], 1'b0)
        apb(1'b1, `MGBS_OFF_DISPLAY, 32'h1);
        repeat (3) @(posedge clk);
        `CHK(display_wide, 1'b1)
        `CHK(pad_oe[30:25], 6'h3F)
        `CHK(pad_out[30:25], display_upper_data)
        `CHK(jtag_in, 32'h0)
        apb(1'b1, `MGBS_OFF_DISPLAY, 32'h0);
        repeat (3) @(posedge clk);
        `CHK(display_wide, 1'b0)
        `CHK(pad_oe[30:25], jtag_drive.enable[30:25])
        $display("test dedicated pins done");

        apb(1'b0, 32'h0000_0040, 32'h0);
        `CHK({err, rd}, {1'b1, 32'h0})
        apb(1'b1, 32'h0000_0100, 32'hFFFF_FFFF);
        `CHK(err, 1'b1)
        $display("test unmapped done");
        test_done();
    end
endmodule
